// ### rtl/hdb_doorbell_regs.sv
// host/adapter signalling registers: completion word, refuse status, doorbell
// assumes both register ports and the engine inputs run on clk_in
// How it works
// - completion of an immediate command raises no host interrupt
// - on completion the device sets completion bit 31
// - on completion bit 30 shows failure, zero on success
// - error code goes in bits 7..0; meaningful only while bit 30 set
// - refuse status reads one while the refuse flag is active, else zero
// - writes to refuse status never change the flag
// - host write one to doorbell bit 0 sets it and interrupts adapter
// - host setting doorbell bit 1 interrupts adapter: command loaded
// - local write one clears a doorbell bit; zero leaves it
// - heartbeat request on bit 3 is answered by the heartbeat reply bit
// - each host write of one to bit 4 toggles the refuse flag
// - while refusing, no new transactions start toward the host
// - heartbeat reply is host doorbell bit 6 and interrupts the host
`include "hdb_map.svh"
`timescale 1ns/1ps
`default_nettype none

module hdb_doorbell_regs #(
    parameter int ERR_W = 8
) (
    // clock, reset, enable
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // host (pci) register port
    input wire hdb_pkg::hdb_bus_req_s pci_req_in,
    output logic [31:0] pci_rdata_out,
    // local-bus register port
    input wire hdb_pkg::hdb_bus_req_s loc_req_in,
    output logic [31:0] loc_rdata_out,
    // command engine completion report
    input wire hdb_pkg::hdb_completion_s completion_in,
    // adapter-side interrupt and doorbell view
    output logic adapter_irq_out,
    output logic [`HDB_DB_USED_W-1:0] doorbell_out,
    // heartbeat reply toward the host-facing doorbell
    output logic [31:0] host_db_set_out,
    // refuse gating of adapter-to-host transactions
    output logic refuse_out,
    input wire logic host_txn_req_in,
    output logic host_txn_req_out
);

    // the error field must fit below the failure bit and inside the engine's
    // report; a wider field would pick up bits that the engine never drives
    if (ERR_W < 1 || ERR_W > `HDB_CMP_FAIL_BIT ||
        ERR_W > $bits(hdb_pkg::hdb_completion_s) - 2) begin : g_bad_err_w
        $error("hdb_doorbell_regs: ERR_W out of range");
    end

    // register state
    // the doorbell keeps bits 4..0 only; the unused upper bits read as zero
    logic [31:0] completion_q;
    logic [31:0] completion_d;
    logic [`HDB_DB_USED_W-1:0] doorbell_q;
    logic [`HDB_DB_USED_W-1:0] doorbell_d;
    logic refuse_q;
    logic refuse_d;
    logic [31:0] host_db_set_q;
    logic [31:0] host_db_set_d;
    logic [31:0] pci_rdata_q;
    logic [31:0] loc_rdata_q;

    // address match helper, used on both ports
    // exact byte compare: no partial decode, so nothing aliases
    function automatic logic hit(input hdb_pkg::hdb_bus_req_s req, input logic [7:0] ofs);
        hit = (req.addr == ofs);
    endfunction : hit

    // read mux shared by both ports; unmapped offsets read zero
    // the three hits never coincide, so the order of the ifs is moot
    function automatic logic [31:0] rd_mux(input logic c, input logic r, input logic d,
                                           input logic [31:0] cv, input logic rv,
                                           input logic [`HDB_DB_USED_W-1:0] dv);
        logic [31:0] v;
        v = `HDB_ZERO_WORD;
        if (c) begin
            v = cv;
        end
        if (r) begin
            v = rv ? `HDB_REFUSE_ON_WORD : `HDB_ZERO_WORD;
        end
        if (d) begin
            v = {{(32 - `HDB_DB_USED_W){1'b0}}, dv};
        end
        rd_mux = v;
    endfunction : rd_mux

    // address decode on both ports
    wire pci_cmp_hit = hit(pci_req_in, `HDB_PCI_COMPLETION_OFS);
    wire pci_ref_hit = hit(pci_req_in, `HDB_PCI_REFUSE_OFS);
    wire pci_db_hit = hit(pci_req_in, `HDB_PCI_DOORBELL_OFS);
    wire loc_cmp_hit = hit(loc_req_in, `HDB_LOC_COMPLETION_OFS);
    wire loc_ref_hit = hit(loc_req_in, `HDB_LOC_REFUSE_OFS);
    wire loc_db_hit = hit(loc_req_in, `HDB_LOC_DOORBELL_OFS);

    // write strobes; a refuse-status write is decoded but has no effect
    // ce_in is applied at the registers, which keeps these strobes plain
    wire pci_cmp_wr = pci_req_in.wr && pci_cmp_hit;
    wire pci_db_wr = pci_req_in.wr && pci_db_hit;
    wire loc_cmp_wr = loc_req_in.wr && loc_cmp_hit;
    wire loc_db_wr = loc_req_in.wr && loc_db_hit;

    // doorbell set (host) and clear (local) masks
    // host write one sets
    wire [`HDB_DB_USED_W-1:0] db_set = pci_db_wr ? pci_req_in.wdata[`HDB_DB_USED_W-1:0]
                                                 : `HDB_DOORBELL_RST;
    wire [`HDB_DB_USED_W-1:0] db_clr = loc_db_wr ? loc_req_in.wdata[`HDB_DB_USED_W-1:0]
                                                 : `HDB_DOORBELL_RST;

    wire refuse_toggle = db_set[`HDB_DB_REFUSE_BIT];
    wire hb_request = db_set[`HDB_DB_HEARTBEAT_BIT];

    // the new completion word the engine reports
    // bits 29..8 come back zero so stale host bits never pose as status
    // error code in low bits
    wire [31:0] cmp_report = {1'b1, completion_in.fail,
                              {(30 - ERR_W){1'b0}},
                              completion_in.err_code[ERR_W-1:0]};

    // completion next value: local write over host write, engine report over both
    // so that a host clear racing the completion cannot lose the done bit
    always_comb begin
        completion_d = completion_q;
        if (pci_cmp_wr) begin
            completion_d = pci_req_in.wdata;
        end
        // firmware beats the host when both write in one cycle
        if (loc_cmp_wr) begin
            completion_d = loc_req_in.wdata;
        end
        if (completion_in.done) begin
            completion_d = cmp_report;
        end
    end

    // doorbell: a host set in the same cycle as a local clear wins
    // bit 4 rides in the same mask but never reaches the adapter interrupt
    // set wins over clear
    assign doorbell_d = (doorbell_q & ~db_clr) | db_set;

    // refuse flag moves only on the doorbell refuse bit
    // it flips on the edge that takes the host write; firmware clears bit 4
    // later, and the status word is only worth reading after that
    // status writes ignored
    assign refuse_d = refuse_toggle ? ~refuse_q : refuse_q;

    // heartbeat reply is a one-cycle set mask toward the host doorbell
    // a pulse, not a level: the host-facing register keeps the bit itself
    // reply on bit six
    assign host_db_set_d = hb_request ? (32'h0000_0001 << `HDB_HOST_DB_HB_REPLY_BIT)
                                      : `HDB_ZERO_WORD;

    // state update; everything holds while ce_in is low
    // reset ignores ce_in so a frozen block still leaves reset clean
    // reset to zero
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            completion_q <= `HDB_COMPLETION_RST;
            doorbell_q <= `HDB_DOORBELL_RST;
            refuse_q <= `HDB_REFUSE_RST;
            host_db_set_q <= `HDB_ZERO_WORD;
        end else if (ce_in) begin
            completion_q <= completion_d;
            doorbell_q <= doorbell_d;
            refuse_q <= refuse_d;
            host_db_set_q <= host_db_set_d;
        end
    end

    // read words of both ports, chosen outside the clocked block
    // a read and a write in one cycle return the word as it stood before
    wire [31:0] pci_rd_word = rd_mux(pci_cmp_hit, pci_ref_hit, pci_db_hit,
                                     completion_q, refuse_q, doorbell_q);
    wire [31:0] loc_rd_word = rd_mux(loc_cmp_hit, loc_ref_hit, loc_db_hit,
                                     completion_q, refuse_q, doorbell_q);

    // read data, one cycle after the read strobe, held until the next read
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pci_rdata_q <= `HDB_RDATA_RST;
            loc_rdata_q <= `HDB_RDATA_RST;
        end else if (ce_in) begin
            if (pci_req_in.rd) begin
                pci_rdata_q <= pci_rd_word;
            end
            if (loc_req_in.rd) begin
                loc_rdata_q <= loc_rd_word;
            end
        end
    end

    // outputs
    assign pci_rdata_out = pci_rdata_q;
    assign loc_rdata_out = loc_rdata_q;
    assign doorbell_out = doorbell_q;
    assign refuse_out = refuse_q;
    assign host_db_set_out = host_db_set_q;
    assign adapter_irq_out = |doorbell_q[`HDB_DB_HEARTBEAT_BIT:`HDB_DB_NEW_TCB_BIT];
    // the gate is combinational so a refuse holds back the very next request
    // block host transactions
    assign host_txn_req_out = host_txn_req_in && !refuse_q;
    // completion_q feeds only the read mux; the host learns of it by polling
    // no host interrupt

endmodule : hdb_doorbell_regs

`default_nettype wire

// ### rtl/hdb_map.svh
// register offsets, field positions and reset values for the doorbell block
// assumes byte addresses on both register ports, one 32-bit word per register
`ifndef HDB_MAP_SVH
`define HDB_MAP_SVH

// host-side (pci) offsets
`define HDB_PCI_COMPLETION_OFS 8'h4C
`define HDB_PCI_REFUSE_OFS 8'h50
`define HDB_PCI_DOORBELL_OFS 8'h60

// local-side alias offsets
`define HDB_LOC_COMPLETION_OFS 8'hCC
`define HDB_LOC_REFUSE_OFS 8'hD0
`define HDB_LOC_DOORBELL_OFS 8'hE0

// completion register fields
`define HDB_CMP_DONE_BIT 31
`define HDB_CMP_FAIL_BIT 30
`define HDB_CMP_ERR_LSB 0

// doorbell bits
`define HDB_DB_NEW_TCB_BIT 0
`define HDB_DB_CMD_LOADED_BIT 1
`define HDB_DB_SLAVE_OP_BIT 2
`define HDB_DB_HEARTBEAT_BIT 3
`define HDB_DB_REFUSE_BIT 4
`define HDB_DB_USED_W 5

// heartbeat reply bit in the host-facing interrupt doorbell
`define HDB_HOST_DB_HB_REPLY_BIT 6

// reset values
`define HDB_COMPLETION_RST 32'h0000_0000
`define HDB_DOORBELL_RST 5'h00
`define HDB_REFUSE_RST 1'b0
`define HDB_RDATA_RST 32'h0000_0000
`define HDB_ZERO_WORD 32'h0000_0000
`define HDB_REFUSE_ON_WORD 32'h0000_0001

`endif

// ### rtl/hdb_pkg.sv
// types shared by the doorbell block and its surroundings
// assumes the constants live in hdb_map.svh
package hdb_pkg;

    // one register-port request, valid for one clock
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } hdb_bus_req_s;

    // completion report from the command engine
    typedef struct packed {
        logic done;
        logic fail;
        logic [7:0] err_code;
    } hdb_completion_s;

endpackage : hdb_pkg

// ### bench/hdb_chk.sv
// checker of the doorbell block port relations
// assumes it is bound onto hdb_doorbell_regs
`timescale 1ns/1ps
`default_nettype none
module hdb_chk (
    // clock and control
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    // register ports and engine
    input wire hdb_pkg::hdb_bus_req_s pci_req_in,
    input wire logic [31:0] pci_rdata_out,
    input wire hdb_pkg::hdb_bus_req_s loc_req_in,
    input wire hdb_pkg::hdb_completion_s completion_in,
    // adapter and host side
    input wire logic adapter_irq_out,
    input wire logic [4:0] doorbell_out,
    input wire logic [31:0] host_db_set_out,
    input wire logic refuse_out,
    input wire logic host_txn_req_in,
    input wire logic host_txn_req_out
);
    // taken doorbell writes and host reads; ce low means nothing was taken
    wire logic hw = ce_in && pci_req_in.wr && pci_req_in.addr == 8'h60;
    wire logic lw = ce_in && loc_req_in.wr && loc_req_in.addr == 8'hE0;
    wire logic hr = ce_in && pci_req_in.rd;
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    // engine report, then a host read of the completion word
    sequence done_then_rd;
        ce_in && completion_in.done ##1 hr && pci_req_in.addr == 8'h4C;
    endsequence
    irq_from_bits_a: assert property (adapter_irq_out == |doorbell_out[3:0])
        else $error("adapter irq wrong");
    txn_gate_a: assert property (host_txn_req_out == (host_txn_req_in && !refuse_out))
        else $error("txn gate wrong");
    done_word_a: assert property (done_then_rd |=>
        pci_rdata_out[31:30] == {1'b1, $past(completion_in.fail, 2)}
        && pci_rdata_out[7:0] == $past(completion_in.err_code, 2))
        else $error("completion word wrong");
    bell_set_a: assert property (hw |=>
        (doorbell_out[3:0] & $past(pci_req_in.wdata[3:0])) == $past(pci_req_in.wdata[3:0]))
        else $error("doorbell set lost");
    bell_clear_a: assert property (lw && !hw |=>
        doorbell_out == ($past(doorbell_out) & ~$past(loc_req_in.wdata[4:0])))
        else $error("doorbell clear wrong");
    beat_reply_a: assert property (hw && pci_req_in.wdata[3] |=>
        host_db_set_out == 32'h0000_0040)
        else $error("heartbeat reply missing");
    no_cmp_irq_a: assert property (ce_in && !(hw && pci_req_in.wdata[3]) |=>
        host_db_set_out == 32'h0000_0000)
        else $error("host interrupt without heartbeat");
    refuse_toggle_a: assert property (hw && pci_req_in.wdata[4] |=> $changed(refuse_out))
        else $error("refuse flag not toggled");
    refuse_hold_a: assert property (!(hw && pci_req_in.wdata[4]) |=> $stable(refuse_out))
        else $error("refuse flag moved");
    refuse_read_a: assert property (hr && pci_req_in.addr == 8'h50 |=>
        pci_rdata_out == {31'h0000_0000, $past(refuse_out)})
        else $error("refuse status wrong");
endmodule : hdb_chk
// attach to every doorbell block
bind hdb_doorbell_regs hdb_chk u_chk (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .pci_req_in(pci_req_in), .pci_rdata_out(pci_rdata_out), .loc_req_in(loc_req_in),
    .completion_in(completion_in), .adapter_irq_out(adapter_irq_out),
    .doorbell_out(doorbell_out), .host_db_set_out(host_db_set_out), .refuse_out(refuse_out),
    .host_txn_req_in(host_txn_req_in), .host_txn_req_out(host_txn_req_out));
`default_nettype wire

// ### bench/hdb_host_model.sv
// host driver model on the pci register port
// assumes read data is registered, valid the cycle after the read
`timescale 1ns/1ps
`default_nettype none
module hdb_host_model (
    // clock and port
    input wire logic clk_in,
    input wire logic [31:0] rdata_in,
    output var hdb_pkg::hdb_bus_req_s req_out
);
    initial req_out = '0;
    // one word access; a released bus shows inverted leftovers, not the old word
    task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge clk_in);
        #1 req_out = '{wr: wr, rd: !wr, addr: a, wdata: d};
        @(posedge clk_in);
        #1 req_out = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
        q = rdata_in;
    endtask : acc
    task automatic poll(output logic [31:0] q);
        for (int i = 0; i < 16; i++) begin
            acc(1'b0, 8'h4C, 32'h0000_0000, q);
            if (q[31]) break;
        end
    endtask : poll
endmodule : hdb_host_model
`default_nettype wire

// ### bench/tb_top.sv
// bench for the doorbell block: host model on pci, bench on local side
// assumes the checker binds itself onto the design
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    hdb_pkg::hdb_bus_req_s pci_req_in;
    hdb_pkg::hdb_bus_req_s loc_req_in = '0;
    hdb_pkg::hdb_completion_s completion_in = '0;
    logic [31:0] pci_rdata_out, host_db_set_out, loc_rdata, q;
    logic ce = 1'b1;
    logic txn_req = 1'b1;
    logic [4:0] doorbell_out;
    logic adapter_irq_out, refuse_out, host_txn_req_out;
    logic [7:0] ofs [3] = '{8'h4C, 8'h50, 8'h60};
    int miscompares = 0;
    int checked = 0;
    // 100 MHz clock
    always #5 clk_in = ~clk_in;
    hdb_host_model host (.clk_in(clk_in), .rdata_in(pci_rdata_out), .req_out(pci_req_in));
    hdb_doorbell_regs dut (.clk_in(clk_in), .rst_in(rst_in), .ce_in(ce),
        .pci_req_in(pci_req_in), .pci_rdata_out(pci_rdata_out), .loc_req_in(loc_req_in),
        .loc_rdata_out(loc_rdata), .completion_in(completion_in),
        .adapter_irq_out(adapter_irq_out), .doorbell_out(doorbell_out),
        .host_db_set_out(host_db_set_out), .refuse_out(refuse_out),
        .host_txn_req_in(txn_req), .host_txn_req_out(host_txn_req_out));
    // compare and count
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // local-bus write, held through the taking edge
    task automatic lwr(input logic [31:0] d);
        @(posedge clk_in);
        #1 loc_req_in = '{wr: 1'b1, rd: 1'b0, addr: 8'hE0, wdata: d};
        @(posedge clk_in);
        #1 loc_req_in = '{wr: 1'b0, rd: 1'b0, addr: 8'h1F, wdata: ~d};
    endtask : lwr
    // local-bus read; the word is taken once the strobe edge has passed
    task automatic lrd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk_in);
        #1 loc_req_in = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk_in);
        #1 loc_req_in = '{wr: 1'b0, rd: 1'b0, addr: 8'h1F, wdata: 32'hFFFF_FFFF};
        d = loc_rdata;
    endtask : lrd
    // every register word must read zero after a reset
    task automatic zero_words();
        foreach (ofs[i]) begin
            host.acc(1'b0, ofs[i], 32'h0000_0000, q);
            chk("reset word", q, 32'h0000_0000);
        end
    endtask : zero_words
    task automatic close_out();
        if (miscompares == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        zero_words();
        // failed then good command; the poll overlaps the end of the report
        for (int i = 0; i < 2; i++) begin
            host.acc(1'b1, 8'h4C, 32'h0000_0000, q);
            completion_in = '{done: 1'b1, fail: i == 0, err_code: i == 0 ? 8'h5A : 8'h00};
            fork
                host.poll(q);
                #10 completion_in.done = 1'b0;
            join
            chk("completion", q, i == 0 ? 32'hC000_005A : 32'h8000_0000);
            chk("irq", {31'h0000_0000, adapter_irq_out}, 32'h0000_0000);
            chk("host irq", host_db_set_out, 32'h0000_0000);
        end
        lrd(8'hCC, q);
        chk("local completion", q, 32'h8000_0000);
        // parameter word assumed in place before bit 2 is rung
        host.acc(1'b1, 8'h60, 32'h0000_000F, q);
        chk("beat reply", host_db_set_out, 32'h0000_0040);
        host.acc(1'b0, 8'h60, 32'h0000_0000, q);
        chk("doorbell", q, 32'h0000_000F);
        lrd(8'hE0, q);
        chk("local bells", q, 32'h0000_000F);
        lwr(32'h0000_0007);
        chk("bells left", {27'h0000_000, doorbell_out}, 32'h0000_0008);
        chk("irq high", {31'h0000_0000, adapter_irq_out}, 32'h0000_0001);
        lwr(32'h0000_0008);
        chk("irq low", {31'h0000_0000, adapter_irq_out}, 32'h0000_0000);
        // refuse toggled twice; bell bit cleared before the status is trusted
        for (int i = 1; i >= 0; i--) begin
            host.acc(1'b1, 8'h60, 32'h0000_0010, q);
            lwr(32'h0000_0010);
            host.acc(1'b1, 8'h50, 32'h0000_0000, q);
            host.acc(1'b0, 8'h50, 32'h0000_0000, q);
            chk("refuse status", q, i);
            lrd(8'hD0, q);
            chk("local refuse", q, i);
            chk("txn gate", {31'h0000_0000, host_txn_req_out}, 32'h1 - i);
        end
        // a frozen block takes no write, and the request gate follows its input
        ce = 1'b0;
        txn_req = 1'b0;
        host.acc(1'b1, 8'h60, 32'h0000_0001, q);
        chk("frozen bells", {27'h0000_000, doorbell_out}, 32'h0000_0000);
        chk("txn idle", {31'h0000_0000, host_txn_req_out}, 32'h0000_0000);
        ce = 1'b1;
        txn_req = 1'b1;
        host.acc(1'b0, 8'h70, 32'h0000_0000, q);
        chk("unmapped read", q, 32'h0000_0000);
        // mid-run reset with bells rung and refuse active
        host.acc(1'b1, 8'h60, 32'h0000_001F, q);
        rst_in = 1'b1;
        repeat (2) @(posedge clk_in);
        #1 rst_in = 1'b0;
        zero_words();
        chk("reset refuse", {31'h0000_0000, refuse_out}, 32'h0000_0000);
        close_out();
    end
    // watchdog: the sequence needs well under 200 cycles
    initial begin
        #20000;
        miscompares++;
        close_out();
    end
endmodule : tb_top
`default_nettype wire
